// *** ais_sequencer.sv ***
// input-scan sequencer with 16-word result buffer and interrupt
// assumes the converter core takes a one-cycle start and answers with
// a one-cycle done pulse carrying a 10-bit result; inputs are synchronous

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RL1 - scan enable takes positive input from sequence
// RL2 - lowest enabled input first, then ascending
// RL3 - samples_per_interrupt plus one scanned conversions, interrupt, restart scan
// RL4 - all-ones count interrupts on sixteenth conversion
// RL5 - single buffer refills from location zero
// RL6 - alternate off: always multiplexer A selection
// RL7 - multiplexer B fields ignored when alternate off
// RL8 - sixteen-bit mask picks inputs to scan
// RL9 - results written to sequential locations 0..F
// RL10 - scanning overrides multiplexer A positive field
// RL11 - negative select clear picks negative reference
// RL12 - skip disabled inputs, wrap, one input per conversion
module ais_sequencer #(
	parameter int CH_NUM = 16, // analog inputs
	parameter int RES_W = 10 // result width
) (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_SYS_RST,
	// register port
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [31:0] I_REG_WDATA,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	output logic [31:0] O_REG_RDATA,
	// converter core
	output logic O_CONV_START,
	input wire logic I_CONV_DONE,
	input wire logic [9:0] I_CONV_RESULT,
	// analog multiplexer selection
	output logic [3:0] O_POS_SEL,
	output logic O_NEG_SEL_AN1,
	// interrupt
	output logic O_IRQ
);
	// elaboration check: the search, buffer and fields are fixed at 16 x 10
	if (CH_NUM != 16 || RES_W != 10) begin : g_bad_param
		$error("ais_sequencer serves 16 inputs of 10 bits only");
	end

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [31:0] ctrl_q; // converter_control_two
	logic [31:0] chsel_q; // channel_select_register
	logic [15:0] mask_q; // scan_select_mask
	logic [1:0] ev_q; // sticky events
	logic [1:0] evmask_q; // event mask
	logic [31:0] rdata_q; // read data register
	logic [9:0] buf_q [16]; // result_buffer
	logic [3:0] wptr_q; // next buffer location
	logic [3:0] cnt_q; // conversions since last interrupt
	logic [3:0] ch_q; // channel under conversion
	logic started_q; // first channel of a run chosen
	ais_pkg::ais_state_t state_q;

	// decoded control fields
	wire scan_en = ctrl_q[ais_pkg::CTRL_SCAN_EN_BIT];
	wire run_en = ctrl_q[ais_pkg::CTRL_RUN_BIT];
	wire alt_mode = ctrl_q[ais_pkg::CTRL_ALTERNATE_INPUT_MODE_BIT];
	wire buffer_split_mode = ctrl_q[ais_pkg::CTRL_BUFFER_SPLIT_MODE_BIT];
	wire [3:0] samples_per_interrupt = ctrl_q[ais_pkg::CTRL_SAMPLES_PER_INTERRUPT_LSB +: 4];
	wire [3:0] sa = chsel_q[ais_pkg::CHSEL_SA_LSB +: 4];
	wire na = chsel_q[ais_pkg::CHSEL_NA_BIT];
	wire [3:0] sb = chsel_q[ais_pkg::CHSEL_SB_LSB +: 4];
	wire nb = chsel_q[ais_pkg::CHSEL_NB_BIT];

	////////////////////////////////////////////////////////////////////////
	// next enabled input search: lowest set mask bit above base, else wrap
	function automatic logic [3:0] next_ch(input logic [15:0] m,
		input logic [3:0] base, input logic from_start);
		logic [3:0] r;
		logic found;
		r = 4'h0;
		found = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (m[i] && (from_start || i > int'(base))) begin
				r = 4'(i);
				found = 1'b1;
			end
		end
		if (!found) begin
			for (int i = 15; i >= 0; i--) begin
				if (m[i])
					r = 4'(i);
			end
		end
		return r;
	endfunction

	// alternate sample phase: B selection on odd samples when enabled
	logic alt_b_q;
	wire use_b = alt_mode && alt_b_q; // RL6 RL7
	wire [3:0] fixed_pos = use_b ? sb : sa;
	wire fixed_neg = use_b ? nb : na;
	assign O_POS_SEL = scan_en ? ch_q : fixed_pos; // RL1 RL10
	assign O_NEG_SEL_AN1 = fixed_neg; // RL11

	////////////////////////////////////////////////////////////////////////
	// register decode
	wire wr_ctrl = I_REG_WR && I_REG_ADDR == {4'h0, ais_pkg::ADDR_CTRL};
	wire wr_chsel = I_REG_WR && I_REG_ADDR == {4'h0, ais_pkg::ADDR_CHSEL};
	wire wr_mask = I_REG_WR && I_REG_ADDR == {4'h0, ais_pkg::ADDR_MASK};
	wire wr_ev = I_REG_WR && I_REG_ADDR == {4'h0, ais_pkg::ADDR_IRQ_STAT};
	wire wr_evm = I_REG_WR && I_REG_ADDR == {4'h0, ais_pkg::ADDR_IRQ_MASK};
	wire buf_hit = I_REG_ADDR[7:4] == ais_pkg::ADDR_BUF_FIRST[7:4];
	// control words live only in the low page; pages other than it and the buffer page read 0
	wire reg_hit = I_REG_ADDR[7:4] == 4'h0;

	// conversion completion and interrupt point
	wire conv_end = state_q == ais_pkg::ST_CONVERT && I_CONV_DONE;
	wire last_conv = conv_end && cnt_q == samples_per_interrupt; // RL3 RL4
	logic buf_half_q; // which half fills in split mode

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (buf_hit)
			rd_mux = {22'h0, buf_q[I_REG_ADDR[3:0]]};
		else if (reg_hit) begin
			case (I_REG_ADDR[3:0])
				ais_pkg::ADDR_CTRL: rd_mux = ctrl_q;
				ais_pkg::ADDR_CHSEL: rd_mux = chsel_q;
				ais_pkg::ADDR_MASK: rd_mux = {16'h0, mask_q};
				ais_pkg::ADDR_IRQ_STAT: rd_mux = {30'h0, ev_q};
				ais_pkg::ADDR_IRQ_MASK: rd_mux = {30'h0, evmask_q};
				ais_pkg::ADDR_STATUS:
					rd_mux = {16'h0, 2'(state_q), 1'b0, buf_half_q,
						wptr_q, cnt_q, ch_q};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			ctrl_q <= ais_pkg::CTRL_RST;
			chsel_q <= ais_pkg::CHSEL_RST;
			mask_q <= ais_pkg::MASK_RST;
			evmask_q <= 2'h0;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (wr_ctrl)
				ctrl_q <= I_REG_WDATA;
			if (wr_chsel)
				chsel_q <= I_REG_WDATA;
			if (wr_mask)
				mask_q <= I_REG_WDATA[15:0]; // RL8
			if (wr_evm)
				evmask_q <= I_REG_WDATA[1:0];
			rdata_q <= I_REG_RD ? rd_mux : 32'h0000_0000;
		end
	end
	assign O_REG_RDATA = rdata_q;

	// sticky events: a new event wins over a clear in the same cycle
	wire [1:0] ev_set = {1'b0, last_conv};
	always_ff @(posedge I_CORE_CLK) begin
		if (I_SYS_RST)
			ev_q <= 2'h0;
		else
			ev_q <= (ev_q & ~(wr_ev ? I_REG_WDATA[1:0] : 2'h0)) | ev_set;
	end
	assign O_IRQ = |(ev_q & evmask_q);

	////////////////////////////////////////////////////////////////////////
	// sequencer: sample, convert, store, advance
	ais_pkg::ais_state_t state_d;
	always_comb begin
		case (state_q)
			ais_pkg::ST_IDLE:
				state_d = run_en ? ais_pkg::ST_SAMPLE : ais_pkg::ST_IDLE;
			ais_pkg::ST_SAMPLE:
				state_d = ais_pkg::ST_CONVERT;
			ais_pkg::ST_CONVERT: begin
				if (!I_CONV_DONE)
					state_d = ais_pkg::ST_CONVERT; // RL12
				else
					state_d = run_en ? ais_pkg::ST_SAMPLE : ais_pkg::ST_IDLE;
			end
			default: state_d = ais_pkg::ST_IDLE;
		endcase
	end
	assign O_CONV_START = state_q == ais_pkg::ST_SAMPLE;

	always_ff @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			state_q <= ais_pkg::ST_IDLE;
			wptr_q <= 4'h0;
			cnt_q <= 4'h0;
			ch_q <= 4'h0;
			started_q <= 1'b0;
			alt_b_q <= 1'b0;
			buf_half_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == ais_pkg::ST_IDLE && run_en && !started_q) begin
				ch_q <= next_ch(mask_q, 4'h0, 1'b1); // RL2
				started_q <= 1'b1;
			end
			if (!run_en && state_q == ais_pkg::ST_IDLE)
				started_q <= 1'b0;
			if (conv_end) begin
				alt_b_q <= alt_mode && !alt_b_q;
				if (last_conv) begin
					cnt_q <= 4'h0;
					buf_half_q <= buffer_split_mode && !buf_half_q;
					wptr_q <= (buffer_split_mode && !buf_half_q) ? 4'h8 : 4'h0; // RL5
					ch_q <= next_ch(mask_q, 4'h0, 1'b1); // RL3
				end else begin
					cnt_q <= cnt_q + 4'h1;
					wptr_q <= wptr_q + 4'h1; // RL9
					ch_q <= next_ch(mask_q, ch_q, 1'b0); // RL12
				end
			end
		end
	end

	// result storage
	always_ff @(posedge I_CORE_CLK) begin
		if (conv_end)
			buf_q[wptr_q] <= I_CONV_RESULT; // RL9
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// while scanning, a fixed-field write must not move the selection
	chk_scan_pos_sel: assert property (@(posedge I_CORE_CLK) // RL1 RL10
		disable iff (I_SYS_RST) (scan_en && $past(scan_en) &&
		$stable(ch_q)) |-> $stable(O_POS_SEL))
		else $error("scan does not drive positive select");
	// fixed mode with alternate off always shows the A field
	chk_fixed_a_sel: assert property (@(posedge I_CORE_CLK) // RL6
		disable iff (I_SYS_RST) (!scan_en && !alt_mode) |->
		O_POS_SEL == sa)
		else $error("mux A selection not used");
	// B negative field has no say while alternate is off
	chk_b_ignored: assert property (@(posedge I_CORE_CLK) // RL7
		disable iff (I_SYS_RST) !alt_mode |-> O_NEG_SEL_AN1 == na)
		else $error("mux B field leaked into selection");
	// a clear negative bit picks the negative reference
	chk_neg_ref: assert property (@(posedge I_CORE_CLK) // RL11
		disable iff (I_SYS_RST) (!alt_mode && !na) |->
		!O_NEG_SEL_AN1)
		else $error("negative reference not selected");
	// every stored result except the one at the interrupt point moves the write pointer by one word
	chk_wptr_step: assert property (@(posedge I_CORE_CLK) // RL9
		disable iff (I_SYS_RST) (conv_end && !last_conv) |=>
		wptr_q == $past(wptr_q) + 4'h1)
		else $error("buffer pointer did not advance");
	// single buffer: the interrupt point sends the pointer home
	chk_refill_zero: assert property (@(posedge I_CORE_CLK) // RL5
		disable iff (I_SYS_RST) (last_conv && !buffer_split_mode) |=>
		wptr_q == 4'h0 && ev_q[0])
		else $error("buffer did not restart at zero");
	// all-ones count: interrupt exactly at the sixteenth result
	chk_irq_count: assert property (@(posedge I_CORE_CLK) // RL4
		disable iff (I_SYS_RST) (conv_end && samples_per_interrupt == 4'hf) |->
		(last_conv == (cnt_q == 4'hf)))
		else $error("interrupt not on sixteenth conversion");
	// with a nonzero mask, a scanned start only ever lands on an enabled input
	chk_scan_enabled: assert property (@(posedge I_CORE_CLK) // RL8
		disable iff (I_SYS_RST) (O_CONV_START && scan_en &&
		mask_q != 16'h0 && !$changed(mask_q)) |-> mask_q[ch_q])
		else $error("scanned input not enabled in mask");
	// full mask: each step before the interrupt point goes to the next channel up
	chk_ascend: assert property (@(posedge I_CORE_CLK) // RL2
		disable iff (I_SYS_RST) (conv_end && !last_conv &&
		mask_q == 16'hffff) |=> ch_q == $past(ch_q) + 4'h1)
		else $error("scan did not ascend");
	// a start follows only a finished conversion or an idle sequencer
	chk_one_conv: assert property (@(posedge I_CORE_CLK) // RL12
		disable iff (I_SYS_RST) O_CONV_START |->
		($past(conv_end) || $past(state_q) == ais_pkg::ST_IDLE))
		else $error("second start before conversion ended");
	// after the interrupt point the scan begins at the first input
	chk_wrap: assert property (@(posedge I_CORE_CLK) // RL3
		disable iff (I_SYS_RST) (last_conv && mask_q == 16'hffff) |=>
		ch_q == 4'h0)
		else $error("scan did not restart at first input");

	// covers for the main scenarios: full scan, skipping, interrupt,
	// and an event that meets a software clear in the same cycle
	cov_full_scan: cover property (@(posedge I_CORE_CLK)
		last_conv && scan_en && mask_q == 16'hffff && samples_per_interrupt == 4'hf);
	cov_skip: cover property (@(posedge I_CORE_CLK)
		conv_end && scan_en && mask_q != 16'hffff);
	cov_irq: cover property (@(posedge I_CORE_CLK) O_IRQ);
	cov_set_clear: cover property (@(posedge I_CORE_CLK)
		last_conv && wr_ev);
endmodule

// *** ais_pkg.sv ***
// package for the input-scan sequencer: register map, fields, reset values
// assumes one core clock and a plain strobe-based register port
package ais_pkg;
	// register word addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0; // converter_control_two
	localparam logic [3:0] ADDR_CHSEL = 4'h1; // channel_select_register
	localparam logic [3:0] ADDR_MASK = 4'h2; // scan_select_mask
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h3; // sticky event flags
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h4; // event mask
	localparam logic [3:0] ADDR_STATUS = 4'h5; // sequencer state
	localparam logic [3:0] ADDR_BUF_BASE = 4'h8; // first word of upper half
	localparam logic [7:0] ADDR_BUF_FIRST = 8'h10; // result words 10..1f
	// control field positions
	localparam int CTRL_SCAN_EN_BIT = 10;
	localparam int CTRL_SAMPLES_PER_INTERRUPT_LSB = 2;
	localparam int CTRL_BUFFER_SPLIT_MODE_BIT = 1;
	localparam int CTRL_ALTERNATE_INPUT_MODE_BIT = 0;
	localparam int CTRL_RUN_BIT = 15;
	// channel select field positions
	localparam int CHSEL_SA_LSB = 16;
	localparam int CHSEL_NA_BIT = 23;
	localparam int CHSEL_SB_LSB = 24;
	localparam int CHSEL_NB_BIT = 31;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CHSEL_RST = 32'h0000_0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	// event bits
	localparam int EV_DONE_BIT = 0; // samples-per-interrupt reached
	localparam int EV_OVR_BIT = 1; // overrun flag; the sequencer never sets it
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONVERT = 2'b10
	} ais_state_t;
endpackage

// *** ais_conv_model.sv ***
// behavioural converter core that answers the sequencer's start pulses
// assumes one core clock; result carries the start index and the channel
module ais_conv_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// request side
	input wire logic i_start,
	input wire logic [3:0] i_pos_sel,
	// answer side
	output logic o_done,
	output logic [9:0] o_result
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////
	int k_q; // start index since reset
	int wait_q; // cycles left before the answer
	logic busy_q = 1'b0; // conversion in flight
	logic [9:0] val_q = 10'h000; // captured result
	// latency alternates between short and slow; result bus is garbage
	// outside the done cycle so a late sample cannot pass by chance
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		o_result <= ~val_q;
		if (i_rst) begin
			k_q <= 0;
			busy_q <= 1'b0;
		end else if (i_start && !busy_q) begin
			val_q <= {k_q[5:0], i_pos_sel};
			wait_q <= (k_q % 2) * 4;
			busy_q <= 1'b1;
			k_q <= k_q + 1;
		end else if (busy_q && wait_q > 0) begin
			wait_q <= wait_q - 1;
		end else if (busy_q) begin
			o_done <= 1'b1;
			o_result <= val_q;
			busy_q <= 1'b0;
		end
	end
endmodule

// *** tb.sv ***
// self-checking bench for the input-scan sequencer
// assumes the converter model answers every start; one 250 MHz clock
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////
	logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
	logic [7:0] addr = 8'h00; // register address
	logic [31:0] wdata = 32'h0, rdata, v;
	logic start, done, neg, irq, irq_d = 1'b0;
	logic [3:0] pos;
	logic [9:0] res;
	logic [4:0] chq[$]; // {neg, pos} seen at each start
	int n_fail = 0, num_checks = 0, cyc = 0, irq_at = 0, b, k, c;
	ais_sequencer ais_sequencer_i (.I_CORE_CLK(clk), .I_SYS_RST(rst),
		.I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr_s),
		.I_REG_RD(rd_s), .O_REG_RDATA(rdata), .O_CONV_START(start),
		.I_CONV_DONE(done), .I_CONV_RESULT(res), .O_POS_SEL(pos),
		.O_NEG_SEL_AN1(neg), .O_IRQ(irq));
	ais_conv_model ais_conv_model_i (.i_clk(clk), .i_rst(rst),
		.i_start(start), .i_pos_sel(pos), .o_done(done), .o_result(res));
	initial begin
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	// monitor: starts, interrupt edge, hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		irq_d <= irq;
		if (irq === 1'b1 && irq_d !== 1'b1)
			irq_at = chq.size();
		if (rst)
			chq.delete();
		else if (start === 1'b1)
			chq.push_back({neg, pos});
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	// run until the n-th start is on the pins, then drop run only, so
	// exactly n conversions happen, and let the last one settle
	task automatic run_until(input logic [31:0] ctrl, input int n);
		b = chq.size();
		wr(8'(ais_pkg::ADDR_CTRL), ctrl);
		while (chq.size() < b + n - 1 || start !== 1'b1)
			@(negedge clk);
		wr(8'(ais_pkg::ADDR_CTRL), ctrl & 32'hffff_7fff);
		repeat (12) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// reset values, unmapped address
		rd(8'(ais_pkg::ADDR_CTRL), v); `CHK(v, ais_pkg::CTRL_RST)
		rd(8'(ais_pkg::ADDR_CHSEL), v); `CHK(v, ais_pkg::CHSEL_RST)
		rd(8'(ais_pkg::ADDR_MASK), v); `CHK(v[15:0], ais_pkg::MASK_RST)
		rd(8'h07, v); `CHK(v, 32'h0)
		wr(8'(ais_pkg::ADDR_IRQ_MASK), 32'h1);
		$display("test reset done");
		// fixed channel: mux A with negative input 1, mux B never used
		wr(8'(ais_pkg::ADDR_CHSEL), 32'h0985_0000);
		run_until(32'h0000_8004, 2);
		`CHK(chq[b], 5'h15)
		`CHK(chq[b + 1], 5'h15)
		`CHK(irq_at - b, 2)
		wr(8'(ais_pkg::ADDR_IRQ_STAT), 32'h1);
		$display("test fixed done");
		// full scan of sixteen inputs, sixteen per interrupt
		wr(8'(ais_pkg::ADDR_CHSEL), 32'h0905_0000);
		wr(8'(ais_pkg::ADDR_MASK), 32'h0000_ffff);
		rd(8'h22, v); `CHK(v, 32'h0)
		run_until(32'h0000_843c, 17);
		for (int i = 0; i < 16; i++) begin
			`CHK(chq[b + i], {1'b0, 4'(i)})
		end
		`CHK(chq[b + 16], 5'h00)
		`CHK(irq_at - b, 16)
		for (int i = 1; i < 16; i++) begin
			k = b + i;
			rd(8'h10 + 8'(i), v); `CHK(v, {22'h0, 6'(k), 4'(i)})
		end
		k = b + 16;
		rd(8'h10, v); `CHK(v, {22'h0, 6'(k), 4'h0})
		wr(8'(ais_pkg::ADDR_IRQ_STAT), 32'h1);
		$display("test full scan done");
		// reset between runs: sequencer state and registers back to idle
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(8'(ais_pkg::ADDR_STATUS), v); `CHK(v, 32'h0)
		wr(8'(ais_pkg::ADDR_IRQ_MASK), 32'h1);
		// sparse mask with wrap, four per interrupt, two rounds
		wr(8'(ais_pkg::ADDR_MASK), 32'h0000_8025);
		run_until(32'h0000_840c, 8);
		for (int i = 0; i < 8; i++) begin
			v = (i % 4 == 0) ? 0 : (i % 4 == 1) ? 2 : (i % 4 == 2) ? 5 : 15;
			`CHK(chq[b + i], {1'b0, v[3:0]})
		end
		`CHK(irq_at - b, 4)
		wr(8'h10, 32'h0000_03ff);
		for (int i = 0; i < 4; i++) begin
			k = b + 4 + i;
			c = (i == 0) ? 0 : (i == 1) ? 2 : (i == 2) ? 5 : 15;
			rd(8'h10 + 8'(i), v); `CHK(v, {22'h0, 6'(k), 4'(c)})
		end
		$display("test sparse done");
		// interrupt masking and write-one clear
		`CHK(irq, 1'b1)
		wr(8'(ais_pkg::ADDR_IRQ_MASK), 32'h0);
		@(negedge clk);
		`CHK(irq, 1'b0)
		rd(8'(ais_pkg::ADDR_IRQ_STAT), v); `CHK(v[0], 1'b1)
		wr(8'(ais_pkg::ADDR_IRQ_MASK), 32'h1);
		@(negedge clk);
		`CHK(irq, 1'b1)
		wr(8'(ais_pkg::ADDR_IRQ_STAT), 32'h1);
		@(posedge clk);
		`CHK(irq, 1'b0)
		$display("test interrupt done");
		complete_run();
	end
endmodule
